// ===== inc/uart_status_map.vh
// register map, field positions and reset values of the uart status block
//
// Overview of operation
// - set line status bit 2 when a received character has wrong parity
// - in fifo mode the parity flag belongs to the character at the fifo head
// - set line status bit 1 when a character completes while the fifo is full
// - on overrun the new character overwrites the receive shift register
// - on overrun the shift register byte is not pushed; stored characters stay
// - line status bit 0 is high while any received character is held
// - parity, overrun and data ready bits are zero after reset
// - modem status reads only; a write to its address loads extra feature control
// - reading modem status clears change flags 3:0
// - status bit 7 is inverted carrier detect, or modem control bit 3 in loopback
// - status bit 6 is inverted ring indicator, or modem control bit 2 in loopback
// - status bit 5 is inverted data set ready, or modem control bit 0 in loopback
// - status bit 4 is inverted clear to send, or modem control bit 1 in loopback
// - change flags 3, 1, 0 set on any change of their input since last read
// - change flag 2 sets only when active low ring input goes 0 to 1
// - modem status interrupt request is high while any change flag is set
`ifndef UART_STATUS_MAP_VH
`define UART_STATUS_MAP_VH

// ==========================================================
// register byte offsets
`define OFS_LINE_STATUS 6'h00
`define OFS_MODEM_STATUS 6'h04
`define OFS_MODEM_CONTROL 6'h08
`define OFS_FIFO_CONTROL 6'h0c
`define OFS_RX_DATA 6'h10
`define OFS_INT_STATUS 6'h14
`define OFS_INT_MASK 6'h18

// ==========================================================
// field positions
`define LS_DATA_READY 0
`define LS_OVERRUN 1
`define LS_PARITY 2
`define MC_DTR 0
`define MC_RTS 1
`define MC_OUT1 2
`define MC_OUT2 3
`define MC_LOOP 4
`define FC_ENABLE 0
`define IRQ_RX_READY 0
`define IRQ_OVERRUN 1
`define IRQ_PARITY 2
`define IRQ_MODEM 3
`define DLT_CTS 0
`define DLT_DSR 1
`define DLT_RI 2
`define DLT_CD 3

// ==========================================================
// reset values and bus answers
`define RST_BYTE 8'h00
`define RST_NIB 4'h0
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ===== rtl/modem_sync.v
// two flop synchroniser for the modem control inputs
`timescale 1ns/1ps
module modem_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // asynchronous levels in, synchronised levels out
  input wire [WIDTH-1:0] async_i,
  output reg [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] meta_ff;

  // ==========================================================
  // reset to the inactive (high) level of the active low inputs
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      meta_ff <= {WIDTH{1'b1}};
      sync_o <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_ff <= async_i;
      sync_o <= meta_ff;
    end
  end

endmodule // modem_sync

// ===== rtl/uart_status_top.v
// line status and modem status part of a uart, with axi4-lite register access
`timescale 1ns/1ps
`include "uart_status_map.vh"
module uart_status_top #(
  parameter PTR_W = 4
) (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // axi4-lite write address
  input wire awvalid_i,
  output reg awready_o,
  input wire [31:0] awaddr_i,
  // axi4-lite write data
  input wire wvalid_i,
  output reg wready_o,
  input wire [31:0] wdata_i,
  input wire [3:0] wstrb_i,
  // axi4-lite write response
  output reg bvalid_o,
  input wire bready_i,
  output reg [1:0] bresp_o,
  // axi4-lite read address
  input wire arvalid_i,
  output reg arready_o,
  input wire [31:0] araddr_i,
  // axi4-lite read data
  output reg rvalid_o,
  input wire rready_i,
  output reg [31:0] rdata_o,
  output reg [1:0] rresp_o,
  // received characters from the receiver
  input wire rx_char_valid_i,
  input wire [7:0] rx_char_data_i,
  input wire rx_char_parity_err_i,
  // active low modem control inputs
  input wire cd_n_i,
  input wire ri_n_i,
  input wire dsr_n_i,
  input wire cts_n_i,
  // register outputs
  output reg [7:0] extra_feature_control_o,
  output reg [7:0] modem_control_o,
  output reg modem_int_req_o,
  output reg irq_o
);

  localparam [PTR_W:0] DEPTH = {1'b1, {PTR_W{1'b0}}};

  // ==========================================================
  // functions
  function mapped;
    input [5:0] a;
    begin
      mapped = (a == `OFS_LINE_STATUS) || (a == `OFS_MODEM_STATUS) ||
               (a == `OFS_MODEM_CONTROL) || (a == `OFS_FIFO_CONTROL) ||
               (a == `OFS_RX_DATA) || (a == `OFS_INT_STATUS) ||
               (a == `OFS_INT_MASK);
    end
  endfunction

  function [PTR_W-1:0] ptr_inc;
    input [PTR_W-1:0] p;
    begin
      ptr_inc = p + 1'b1;
    end
  endfunction

  // ==========================================================
  // declarations
  reg aw_hold_ff;
  reg w_hold_ff;
  reg [5:0] awaddr_ff;
  reg [7:0] wdata_ff;
  reg wstrb_ff;
  reg fifo_en_ff;
  reg [3:0] int_status_ff;
  reg [3:0] int_mask_ff;
  reg [3:0] nxt_int_status;
  reg overrun_ff;
  reg nxt_overrun;
  reg [7:0] rx_shift_ff;
  reg [8:0] rx_mem [0:DEPTH-1];
  reg [PTR_W-1:0] wptr_ff;
  reg [PTR_W-1:0] rptr_ff;
  reg [PTR_W:0] count_ff;
  reg [PTR_W:0] nxt_count;
  reg [3:0] level_ff;
  reg [3:0] delta_ff;
  reg [3:0] nxt_delta;
  reg [3:0] change;
  reg [31:0] rd_value;
  wire [3:0] sync_n;
  wire [3:0] level;
  wire [5:0] rd_addr;
  wire rd_fire;
  wire wr_fire;
  wire wr_en;
  wire [PTR_W:0] capacity;
  wire full;
  wire push;
  wire pop;
  wire flush;
  wire [8:0] head;
  wire head_parity;

  // ==========================================================
  // modem input synchronisers
  modem_sync #(
    .WIDTH(4)
  ) u_modem_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i({cd_n_i, ri_n_i, dsr_n_i, cts_n_i}),
    .sync_o(sync_n)
  );

  // ==========================================================
  // bus handshakes
  assign rd_fire = arvalid_i && arready_o;
  assign rd_addr = araddr_i[5:0];
  assign wr_fire = aw_hold_ff && w_hold_ff && !bvalid_o;
  assign wr_en = wr_fire && wstrb_ff;

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      awready_o <= 1'b1;
      wready_o <= 1'b1;
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 6'h00;
      wdata_ff <= `RST_BYTE;
      wstrb_ff <= 1'b0;
      bvalid_o <= 1'b0;
      bresp_o <= `RESP_OKAY;
      arready_o <= 1'b1;
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= `RESP_OKAY;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff <= awaddr_i[5:0];
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff <= wdata_i[7:0];
        wstrb_ff <= wstrb_i[0];
        wready_o <= 1'b0;
      end
      if (wr_fire)
      begin
        bvalid_o <= 1'b1;
        bresp_o <= mapped(awaddr_ff) ? `RESP_OKAY : `RESP_SLVERR;
        aw_hold_ff <= 1'b0;
        w_hold_ff <= 1'b0;
      end
      else if (bvalid_o && bready_i)
      begin
        bvalid_o <= 1'b0;
        awready_o <= 1'b1;
        wready_o <= 1'b1;
      end
      if (rd_fire)
      begin
        arready_o <= 1'b0;
        rvalid_o <= 1'b1;
        rdata_o <= rd_value;
        rresp_o <= mapped(rd_addr) ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_o && rready_i)
      begin
        rvalid_o <= 1'b0;
        arready_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // read value
  always @*
  begin
    rd_value = 32'h0000_0000;
    case (rd_addr)
      `OFS_LINE_STATUS:
      begin
        rd_value[`LS_DATA_READY] = (count_ff != 0);
        rd_value[`LS_OVERRUN] = overrun_ff;
        rd_value[`LS_PARITY] = head_parity;
      end
      `OFS_MODEM_STATUS: rd_value[7:0] = {level_ff, delta_ff};
      `OFS_MODEM_CONTROL: rd_value[7:0] = modem_control_o;
      `OFS_FIFO_CONTROL: rd_value[`FC_ENABLE] = fifo_en_ff;
      `OFS_RX_DATA: rd_value[7:0] = (count_ff != 0) ? head[7:0] : `RST_BYTE;
      `OFS_INT_STATUS: rd_value[3:0] = int_status_ff;
      `OFS_INT_MASK: rd_value[3:0] = int_mask_ff;
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // control registers
  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      extra_feature_control_o <= `RST_BYTE;
      modem_control_o <= `RST_BYTE;
      fifo_en_ff <= 1'b0;
      int_mask_ff <= `RST_NIB;
    end
    else if (wr_en)
    begin
      case (awaddr_ff)
        `OFS_MODEM_STATUS: extra_feature_control_o <= wdata_ff;
        `OFS_MODEM_CONTROL: modem_control_o <= wdata_ff;
        `OFS_FIFO_CONTROL: fifo_en_ff <= wdata_ff[`FC_ENABLE];
        `OFS_INT_MASK: int_mask_ff <= wdata_ff[3:0];
        default: fifo_en_ff <= fifo_en_ff;
      endcase
    end
  end

  // ==========================================================
  // receive fifo (one place when fifo mode is off)
  assign capacity = fifo_en_ff ? DEPTH : {{PTR_W{1'b0}}, 1'b1};
  assign full = (count_ff >= capacity);
  assign flush = wr_en && (awaddr_ff == `OFS_FIFO_CONTROL) &&
                 (wdata_ff[`FC_ENABLE] != fifo_en_ff);
  assign push = rx_char_valid_i && !full && !flush;
  assign pop = rd_fire && (rd_addr == `OFS_RX_DATA) && (count_ff != 0) && !flush;
  assign head = rx_mem[rptr_ff];
  assign head_parity = (count_ff != 0) && head[8];

  always @*
  begin
    nxt_count = count_ff;
    if (push && !pop)
      nxt_count = count_ff + 1'b1;
    else if (pop && !push)
      nxt_count = count_ff - 1'b1;
  end

  always @(posedge mclk_i)
  begin
    if (push)
      rx_mem[wptr_ff] <= {rx_char_parity_err_i, rx_char_data_i};
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_i || flush)
    begin
      wptr_ff <= {PTR_W{1'b0}};
      rptr_ff <= {PTR_W{1'b0}};
      count_ff <= {(PTR_W+1){1'b0}};
    end
    else
    begin
      if (push)
        wptr_ff <= ptr_inc(wptr_ff);
      if (pop)
        rptr_ff <= ptr_inc(rptr_ff);
      count_ff <= nxt_count;
    end
  end

  // ==========================================================
  // shift register copy and overrun flag
  always @*
  begin
    nxt_overrun = overrun_ff;
    if (rd_fire && (rd_addr == `OFS_LINE_STATUS))
      nxt_overrun = 1'b0;
    if (rx_char_valid_i && full)
      nxt_overrun = 1'b1;
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      rx_shift_ff <= `RST_BYTE;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (rx_char_valid_i)
        rx_shift_ff <= rx_char_data_i;
      overrun_ff <= nxt_overrun;
    end
  end

  // ==========================================================
  // modem levels: cd, ri, dsr, cts
  assign level = modem_control_o[`MC_LOOP] ?
                 {modem_control_o[`MC_OUT2],
                  modem_control_o[`MC_OUT1],
                  modem_control_o[`MC_DTR],
                  modem_control_o[`MC_RTS]} :
                 ~sync_n;

  always @*
  begin
    change = level ^ level_ff;
    change[`DLT_RI] = level_ff[`DLT_RI] && !level[`DLT_RI];
    nxt_delta = delta_ff;
    if (rd_fire && (rd_addr == `OFS_MODEM_STATUS))
      nxt_delta = `RST_NIB;
    nxt_delta = nxt_delta | change;
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      level_ff <= `RST_NIB;
      delta_ff <= `RST_NIB;
      modem_int_req_o <= 1'b0;
    end
    else
    begin
      level_ff <= level;
      delta_ff <= nxt_delta;
      modem_int_req_o <= |nxt_delta;
    end
  end

  // ==========================================================
  // interrupt status, write one to clear, set wins
  always @*
  begin
    nxt_int_status = int_status_ff;
    if (wr_en && (awaddr_ff == `OFS_INT_STATUS))
      nxt_int_status = int_status_ff & ~wdata_ff[3:0];
    if (push)
      nxt_int_status[`IRQ_RX_READY] = 1'b1;
    if (rx_char_valid_i && full)
      nxt_int_status[`IRQ_OVERRUN] = 1'b1;
    if (push && rx_char_parity_err_i)
      nxt_int_status[`IRQ_PARITY] = 1'b1;
    if (|nxt_delta)
      nxt_int_status[`IRQ_MODEM] = 1'b1;
  end

  always @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      int_status_ff <= `RST_NIB;
      irq_o <= 1'b0;
    end
    else
    begin
      int_status_ff <= nxt_int_status;
      irq_o <= |(nxt_int_status & int_mask_ff);
    end
  end

endmodule // uart_status_top

// ===== test/uart_status_props.sv
// port checker of the uart status block
`timescale 1ns/1ps
module uart_status_props (
  // clock and reset
  input wire mclk_i,
  input wire rst_n_i,
  // read bus
  input wire arvalid_i,
  input wire arready_o,
  input wire [31:0] araddr_i,
  input wire rvalid_o,
  input wire rready_i,
  input wire [31:0] rdata_o,
  input wire [1:0] rresp_o,
  // modem side
  input wire cd_n_i,
  input wire ri_n_i,
  input wire dsr_n_i,
  input wire cts_n_i,
  input wire [7:0] modem_control_o,
  input wire modem_int_req_o
);
  // ========================================
  // quiet time of the modem levels
  wire rd_take = arvalid_i && arready_o;
  wire take_ms = rd_take && araddr_i[5:0] == 6'h04;
  wire [3:0] pin_lvl = ~{cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
  wire [3:0] mc_lvl = {modem_control_o[3:2], modem_control_o[0], modem_control_o[1]};
  reg [11:0] pins_ff;
  reg [2:0] quiet_ff;
  wire quiet = take_ms && quiet_ff == 3'h7 && pins_ff == {pin_lvl, modem_control_o};
  always @(posedge mclk_i)
  begin
    pins_ff <= {pin_lvl, modem_control_o};
    if (!rst_n_i || pins_ff != {pin_lvl, modem_control_o})
      quiet_ff <= 3'h0;
    else if (quiet_ff != 3'h7)
      quiet_ff <= quiet_ff + 3'h1;
  end
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ========================================
  // assertions
  a_int_flags: assert property (
    quiet |=> (rdata_o[3:0] != 4'h0) == $past(modem_int_req_o))
    else $error("int request disagrees with change flags");
  a_read_clears: assert property (
    quiet |=> !modem_int_req_o [*2])
    else $error("change flags survive a read");
  a_flag_sticky: assert property (
    modem_int_req_o && !take_ms |=> modem_int_req_o)
    else $error("change flag dropped without a read");
  a_normal_levels: assert property (
    quiet && !modem_control_o[4] |=> rdata_o[7:4] == $past(pin_lvl))
    else $error("modem levels wrong");
  a_loop_levels: assert property (
    quiet && modem_control_o[4] |=> rdata_o[7:4] == $past(mc_lvl))
    else $error("loopback levels wrong");
  a_unmapped_err: assert property (
    rd_take && araddr_i[5:0] > 6'h18 |=> rresp_o == 2'b10 && rdata_o == 32'h0)
    else $error("unmapped read not refused");
  a_read_hold: assert property (
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data not held");
  a_reset_clear: assert property (
    disable iff (1'b0) !rst_n_i |=> !rvalid_o && !modem_int_req_o)
    else $error("outputs not cleared by reset");
  c_loop_read: cover property (quiet && modem_control_o[4]);
  c_flag_read: cover property (take_ms && modem_int_req_o);
  c_unmapped: cover property (rd_take && araddr_i[5:0] > 6'h18);
  c_held_read: cover property (rvalid_o && !rready_i);
endmodule // uart_status_props
bind uart_status_top uart_status_props i_props (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .arvalid_i(arvalid_i),
  .arready_o(arready_o),
  .araddr_i(araddr_i),
  .rvalid_o(rvalid_o),
  .rready_i(rready_i),
  .rdata_o(rdata_o),
  .rresp_o(rresp_o),
  .cd_n_i(cd_n_i),
  .ri_n_i(ri_n_i),
  .dsr_n_i(dsr_n_i),
  .cts_n_i(cts_n_i),
  .modem_control_o(modem_control_o),
  .modem_int_req_o(modem_int_req_o)
);

// ===== test/modem_peer.sv
// modem side model driving the active low modem levels
`timescale 1ns/1ps
module modem_peer (
  // clock
  input wire mclk_i,
  // wanted asserted levels {cd, ri, dsr, cts} and pace
  input wire [3:0] want_i,
  input wire slow_i,
  // active low modem lines
  output wire cd_n_o,
  output wire ri_n_o,
  output wire dsr_n_o,
  output wire cts_n_o
);
  reg [3:0] line_n_ff = 4'hf;
  reg [1:0] lag_ff = 2'h0;
  assign {cd_n_o, ri_n_o, dsr_n_o, cts_n_o} = line_n_ff;
  always @(posedge mclk_i)
  begin
    if (line_n_ff == ~want_i)
      lag_ff <= 2'h0;
    else if (!slow_i || lag_ff == 2'h3)
    begin
      line_n_ff <= ~want_i;
      lag_ff <= 2'h0;
    end
    else
      lag_ff <= lag_ff + 2'h1;
  end
endmodule // modem_peer

// ===== test/test_uart_line_and_modem_status.sv
// self-checking bench of the uart status block
`timescale 1ns/1ps
module test_uart_line_and_modem_status;
  reg mclk_i = 1'b0, rst_n_i = 1'b0, awvalid_i = 1'b0, wvalid_i = 1'b0, bready_i = 1'b0;
  reg arvalid_i = 1'b0, rready_i = 1'b0, rx_char_valid_i = 1'b0, rx_char_parity_err_i = 1'b0;
  reg [31:0] awaddr_i = 32'h0, wdata_i = 32'h0, araddr_i = 32'h0, d;
  reg [3:0] wstrb_i = 4'h1, want = 4'h0, old = 4'h0, nw, gl;
  reg [7:0] rx_char_data_i = 8'h00, e;
  reg slow = 1'b0, oe = 1'b0;
  reg [1:0] r, rsp;
  reg [8:0] q[$];
  wire awready_o, wready_o, bvalid_o, arready_o, rvalid_o, modem_int_req_o, irq_o;
  wire cd_n_i, ri_n_i, dsr_n_i, cts_n_i;
  wire [1:0] bresp_o, rresp_o;
  wire [31:0] rdata_o;
  wire [7:0] extra_feature_control_o, modem_control_o;
  integer err_count = 0, checks = 0, cap = 1, k, lag = 0;
  uart_status_top #(.PTR_W(2)) i_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .awaddr_i(awaddr_i),
    .wvalid_i(wvalid_i), .wready_o(wready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i),
    .bvalid_o(bvalid_o), .bready_i(bready_i), .bresp_o(bresp_o),
    .arvalid_i(arvalid_i), .arready_o(arready_o), .araddr_i(araddr_i),
    .rvalid_o(rvalid_o), .rready_i(rready_i), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .rx_char_valid_i(rx_char_valid_i), .rx_char_data_i(rx_char_data_i),
    .rx_char_parity_err_i(rx_char_parity_err_i),
    .cd_n_i(cd_n_i), .ri_n_i(ri_n_i), .dsr_n_i(dsr_n_i), .cts_n_i(cts_n_i),
    .extra_feature_control_o(extra_feature_control_o), .modem_control_o(modem_control_o),
    .modem_int_req_o(modem_int_req_o), .irq_o(irq_o));
  modem_peer i_peer (.mclk_i(mclk_i), .want_i(want), .slow_i(slow),
    .cd_n_o(cd_n_i), .ri_n_o(ri_n_i), .dsr_n_o(dsr_n_i), .cts_n_o(cts_n_i));
  always #20 mclk_i = ~mclk_i;
  // ========================================
  // tasks
  task chk(input [31:0] s, input [31:0] x, input string n);
  begin
    checks = checks + 1;
    if (s !== x)
    begin
      err_count = err_count + 1;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  end
  endtask
  task print_verdict;
  begin
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  task wr(input [5:0] a, input [7:0] v, output [1:0] b);
  begin
    awaddr_i <= {26'h0, a};
    wdata_i <= {24'h0, v};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do
    begin
      @(posedge mclk_i);
      if (awready_o)
        awvalid_i <= 1'b0;
      if (wready_o)
        wvalid_i <= 1'b0;
    end while (!bvalid_o);
    b = bresp_o;
    bready_i <= 1'b0;
    @(posedge mclk_i);
  end
  endtask
  task rd(input [5:0] a, output [31:0] v);
  begin
    araddr_i <= {26'h0, a};
    arvalid_i <= 1'b1;
    rready_i <= (lag == 0);
    do
    begin
      @(posedge mclk_i);
      if (arready_o)
        arvalid_i <= 1'b0;
      if (rvalid_o && !rready_i)
      begin
        repeat (lag) @(posedge mclk_i);
        rready_i <= 1'b1;
        @(posedge mclk_i);
      end
    end while (!(rvalid_o && rready_i));
    v = rdata_o;
    rsp = rresp_o;
    rready_i <= 1'b0;
    @(posedge mclk_i);
  end
  endtask
  task pushn(input integer n, input pm);
    integer i;
    reg [8:0] c;
  begin
    for (i = 0; i < n; i = i + 1)
    begin
      c = 9'($urandom) | {pm, 8'h00};
      rx_char_valid_i <= 1'b1;
      rx_char_data_i <= c[7:0];
      rx_char_parity_err_i <= c[8];
      if (q.size() < cap)
        q.push_back(c);
      else
        oe = 1'b1;
      @(posedge mclk_i);
    end
    rx_char_valid_i <= 1'b0;
    @(posedge mclk_i);
  end
  endtask
  task chk_ls;
  begin
    rd(6'h00, d);
    chk(d, {29'h0, (q.size() != 0) ? q[0][8] : 1'b0, oe, q.size() != 0}, "ls");
    oe = 1'b0;
  end
  endtask
  task pop;
  begin
    rd(6'h10, d);
    chk(d, {24'h0, q[0][7:0]}, "rx_data");
    void'(q.pop_front());
  end
  endtask
  function [7:0] exp_ms(input [3:0] o, input [3:0] n, input [3:0] g);
    reg [3:0] f;
  begin
    f = (o ^ n) | g;
    f[2] = (o[2] & ~n[2]) | g[2];
    exp_ms = {n, f};
  end
  endfunction
  // ========================================
  // tests
  initial
  begin
    repeat (30000) @(posedge mclk_i);
    err_count = err_count + 1;
    print_verdict;
  end
  initial
  begin
    void'($urandom(32'h7120));
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    chk_ls;
    rd(6'h04, d);
    chk(d, 32'h0, "ms");
    for (k = 0; k < 12; k = k + 1)
    begin
      nw = 4'($urandom);
      gl = 4'($urandom) & ~(old ^ nw);
      slow <= k[0];
      want <= nw ^ gl;
      repeat (12) @(posedge mclk_i);
      want <= nw;
      repeat (12) @(posedge mclk_i);
      e = exp_ms(old, nw, gl);
      chk(modem_int_req_o, e[3:0] != 4'h0, "int_req");
      rd(6'h04, d);
      chk(d, {24'h0, e}, "ms");
      chk(modem_int_req_o, 0, "int_req");
      old = nw;
    end
    for (k = 0; k < 16; k = k + 1)
    begin
      wr(6'h08, 8'h10 | k[7:0], r);
      repeat (8) @(posedge mclk_i);
      rd(6'h04, d);
      chk(d[7:4], {k[3], k[2], k[0], k[1]}, "loop");
    end
    wr(6'h08, 8'h00, r);
    repeat (8) @(posedge mclk_i);
    lag = 3;
    rd(6'h04, d);
    lag = 0;
    chk(d[7:4], old, "ms_held");
    e = 8'($urandom);
    wr(6'h04, e, r);
    chk(extra_feature_control_o, e, "efc");
    wstrb_i <= 4'h0;
    wr(6'h04, ~e, r);
    wstrb_i <= 4'h1;
    chk(extra_feature_control_o, e, "efc_strb");
    rd(6'h04, d);
    chk(d, {24'h0, old, 4'h0}, "ms");
    rd(6'h20, d);
    chk(rsp, 2'b10, "rresp");
    wr(6'h24, 8'hff, r);
    chk(r, 2'b10, "bresp");
    wr(6'h18, 8'h01, r);
    pushn(2, 1'b1);
    chk(irq_o, 1, "irq");
    chk_ls;
    chk_ls;
    wr(6'h18, 8'h00, r);
    chk(irq_o, 0, "irq");
    wr(6'h18, 8'h01, r);
    chk(irq_o, 1, "irq");
    wr(6'h14, 8'h01, r);
    chk(irq_o, 0, "irq");
    pop;
    chk_ls;
    wr(6'h0c, 8'h01, r);
    cap = 4;
    pushn(5, 1'b0);
    repeat (4)
    begin
      chk_ls;
      pop;
    end
    chk_ls;
    print_verdict;
  end
endmodule // test_uart_line_and_modem_status
